/* File: core/scsd_regs.svh */
// Register map, field positions, reset values and timing for the serial unit.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef SCSD_REGS_SVH
`define SCSD_REGS_SVH

// Byte offsets.
`define SCSD_CTRL_OFS 4'h0
`define SCSD_STAT_OFS 4'h4
`define SCSD_DATA_OFS 4'h8

// Control register fields.
`define SCSD_C_RXIE 7
`define SCSD_C_MSTR 5
`define SCSD_C_CLOCK_IDLE_LEVEL_SEL 4
`define SCSD_C_CLOCK_PHASE_SEL 3
`define SCSD_C_OD 2
`define SCSD_C_ON 1
`define SCSD_C_TXIE 0

// Status and control register fields.
`define SCSD_S_RXF 7
`define SCSD_S_ERROR_IRQ_EN 6
`define SCSD_S_OVR 5
`define SCSD_S_MODE_FAULT_FLAG 4
`define SCSD_S_TXE 3
`define SCSD_S_FDEN 2
`define SCSD_S_BAUD_HI 1
`define SCSD_S_BAUD_LO 0

// Reset values of single bits.
`define SCSD_RST_MSTR 1'b1
`define SCSD_RST_CLOCK_PHASE_SEL 1'b1
`define SCSD_RST_TXE 1'b1

// Half a serial clock period in bus clocks less one, for divisors 2, 8, 32 and 128.
`define SCSD_HALF_BD2 7'h00
`define SCSD_HALF_BD8 7'h03
`define SCSD_HALF_BD32 7'h0F
`define SCSD_HALF_BD128 7'h3F

// Last edge index in one byte and the last sample index.
`define SCSD_LAST_EDGE 4'hF
`define SCSD_LAST_SAMP 3'h7

// AXI responses.
`define SCSD_RESP_OK 2'h0
`define SCSD_RESP_ERR 2'h2

`endif

/* File: core/scsd_pkg.sv */
// Types shared by the serial unit.
// Assumes nothing of its surroundings.
package scsd_pkg;
    typedef logic [7:0] scsd_byte_t;
    typedef enum logic {SCSD_IDLE, SCSD_RUN} scsd_state_e;
endpackage : scsd_pkg

/* File: core/scsd_top.sv */
// Byte serial peripheral unit with control, status and data registers.
// Assumes AXI4-Lite from the CPU and pin inputs synchronous to aclk.
//
// Operation
// - Idle clock level follows polarity bit.
// - Both ends need same polarity and phase.
// - Phase bit picks edge timing; resets one.
// - Open-drain pins, pullups off when set.
// - Enable bit; clearing partially resets unit.
// - Transmit-empty interrupt enable gates request.
// - Byte received sets receive-full, may interrupt.
// - Status read then data read clears full.
// - Error enable gates fault and overrun requests.
// - Overrun keeps held byte, drops new one.
// - Status read then data read clears overrun.
// - Slave select rising mid-byte sets fault.
// - Master select low sets fault.
// - Status read then control write clears fault.
// - Handoff to shifter sets transmit-empty; resets set.
// - Data write clears transmit-empty.
// - Fault detect enable; clearing keeps flag.
// - Detect off: no fault; master frees select pin.
// - Select pin released for plain master or when disabled.
// - Baud field divides by 2/8/32/128.
// - Data address: write transmit, read receive.
// - Master select bit; resets to master.
// - Receive interrupt enable; resets clear.
// - Deselected slave floats output, ignores clock.
`timescale 1ns/10ps
`default_nettype none
`include "scsd_regs.svh"

module scsd_top
    import scsd_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial pins.
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    // Pad control and CPU request.
    output logic pullup_en,
    output logic ss_gpio_release,
    output logic irq_req
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic rx_full_irq_en;
    logic master_select;
    logic clock_idle_level_sel;
    logic clock_phase_sel;
    logic open_drain_sel;
    logic unit_on;
    logic tx_empty_irq_en;
    logic error_irq_en;
    logic fault_detect_en;
    logic baud_sel_hi;
    logic baud_sel_lo;
    logic rx_full_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic tx_empty_flag;
    logic rx_arm;
    logic ovr_arm;
    logic mode_fault_flag_arm;
    scsd_byte_t tx_hold;
    scsd_byte_t rx_hold;

    // Engine state.
    scsd_state_e state;
    scsd_byte_t shifter;
    logic [6:0] div_cnt;
    logic [3:0] edge_cnt;
    logic [2:0] samp_cnt;
    logic sck_q;
    logic dout;
    logic sck_prev;
    logic ss_prev;

    // Bus state.
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;

    ////////////////////////////////////////////////////////////////////////
    // Access decode.
    logic wr_do;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic rd_acc;
    logic rd_stat;
    logic rd_data;
    assign wr_do = aw_got && w_got && !s_axi_bvalid;
    assign wr_ctrl = wr_do && wr_lane && wr_addr == `SCSD_CTRL_OFS;
    assign wr_stat = wr_do && wr_lane && wr_addr == `SCSD_STAT_OFS;
    assign wr_data = wr_do && wr_lane && wr_addr == `SCSD_DATA_OFS;
    assign rd_acc = s_axi_arvalid && s_axi_arready;
    assign rd_stat = rd_acc && s_axi_araddr == `SCSD_STAT_OFS;
    assign rd_data = rd_acc && s_axi_araddr == `SCSD_DATA_OFS;

    ////////////////////////////////////////////////////////////////////////
    // Engine events.
    logic [6:0] half_per;
    logic sel;
    logic run;
    logic m_tick;
    logic ev;
    logic lead;
    logic samp;
    logic drive;
    logic din;
    logic start_m;
    logic start_s;
    logic done;
    scsd_byte_t rx_byte;

    always_comb begin
        case ({baud_sel_hi, baud_sel_lo})
            2'b00: half_per = `SCSD_HALF_BD2;
            2'b01: half_per = `SCSD_HALF_BD8;
            2'b10: half_per = `SCSD_HALF_BD32;
            default: half_per = `SCSD_HALF_BD128;
        endcase
    end

    // A slave listens only while selected.
    assign sel = unit_on && !master_select && !ss_n_in;
    assign run = state == SCSD_RUN;
    assign m_tick = run && master_select && div_cnt == half_per;
    assign ev = master_select ? m_tick : (sel && sck_in != sck_prev);
    assign lead = master_select ? (sck_q == clock_idle_level_sel) : (sck_prev == clock_idle_level_sel);
    // Phase zero samples on leading edges, phase one on trailing.
    assign samp = run && ev && (lead != clock_phase_sel);
    assign drive = run && ev && (lead == clock_phase_sel);
    assign din = master_select ? miso_in : mosi_in;
    assign start_m = unit_on && master_select && !run && !tx_empty_flag;
    // Phase zero slaves start on the select falling edge, phase one on the first leading edge.
    assign start_s = sel && !run && (clock_phase_sel ? (ev && lead) : (ss_prev && !ss_n_in));
    assign done = samp && samp_cnt == `SCSD_LAST_SAMP;
    assign rx_byte = {shifter[6:0], din};

    ////////////////////////////////////////////////////////////////////////
    // Shift engine.
    always_ff @(posedge aclk) begin
        if (!aresetn || !unit_on) begin
            state <= SCSD_IDLE;
            shifter <= 8'h00;
            div_cnt <= 7'h00;
            edge_cnt <= 4'h0;
            samp_cnt <= 3'h0;
            sck_q <= clock_idle_level_sel;
            dout <= 1'b0;
        end else if (start_m || start_s) begin
            state <= SCSD_RUN;
            shifter <= tx_hold;
            dout <= tx_hold[7];
            div_cnt <= 7'h00;
            edge_cnt <= 4'h0;
            samp_cnt <= 3'h0;
        end else if (!run) begin
            sck_q <= clock_idle_level_sel;
        end else if (!master_select && ss_n_in) begin
            state <= SCSD_IDLE;
        end else begin
            if (master_select) begin
                div_cnt <= m_tick ? 7'h00 : div_cnt + 7'h01;
                if (m_tick) begin
                    sck_q <= !sck_q;
                    edge_cnt <= edge_cnt + 4'h1;
                    if (edge_cnt == `SCSD_LAST_EDGE) begin
                        state <= SCSD_IDLE;
                    end
                end
            end else if (done) begin
                state <= SCSD_IDLE;
            end
            if (samp) begin
                shifter <= rx_byte;
                samp_cnt <= samp_cnt + 3'h1;
            end
            if (drive) begin
                dout <= shifter[7];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_prev <= 1'b0;
            ss_prev <= 1'b1;
        end else begin
            sck_prev <= sck_in;
            ss_prev <= ss_n_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_full_irq_en <= 1'b0;
            master_select <= `SCSD_RST_MSTR;
            clock_idle_level_sel <= 1'b0;
            clock_phase_sel <= `SCSD_RST_CLOCK_PHASE_SEL;
            open_drain_sel <= 1'b0;
            unit_on <= 1'b0;
            tx_empty_irq_en <= 1'b0;
            error_irq_en <= 1'b0;
            fault_detect_en <= 1'b0;
            baud_sel_hi <= 1'b0;
            baud_sel_lo <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                rx_full_irq_en <= wr_byte[`SCSD_C_RXIE];
                master_select <= wr_byte[`SCSD_C_MSTR];
                clock_idle_level_sel <= wr_byte[`SCSD_C_CLOCK_IDLE_LEVEL_SEL];
                clock_phase_sel <= wr_byte[`SCSD_C_CLOCK_PHASE_SEL];
                open_drain_sel <= wr_byte[`SCSD_C_OD];
                unit_on <= wr_byte[`SCSD_C_ON];
                tx_empty_irq_en <= wr_byte[`SCSD_C_TXIE];
            end
            if (wr_stat) begin
                error_irq_en <= wr_byte[`SCSD_S_ERROR_IRQ_EN];
                fault_detect_en <= wr_byte[`SCSD_S_FDEN];
                baud_sel_hi <= wr_byte[`SCSD_S_BAUD_HI];
                baud_sel_lo <= wr_byte[`SCSD_S_BAUD_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit holding register and its empty flag.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_hold <= 8'h00;
            tx_empty_flag <= `SCSD_RST_TXE;
        end else begin
            if (wr_data) begin
                tx_hold <= wr_byte;
            end
            // A handoff in the same cycle as a write wins.
            if (start_m || start_s || !unit_on) begin
                tx_empty_flag <= 1'b1;
            end else if (wr_data) begin
                tx_empty_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive holding register, full and overrun flags.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_hold <= 8'h00;
            rx_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            rx_arm <= 1'b0;
            ovr_arm <= 1'b0;
        end else begin
            if (done && !rx_full_flag) begin
                rx_hold <= rx_byte;
            end
            if (done && !rx_full_flag) begin
                rx_full_flag <= 1'b1;
            end else if (rd_data && rx_arm) begin
                rx_full_flag <= 1'b0;
            end
            if (done && rx_full_flag) begin
                overrun_flag <= 1'b1;
            end else if (rd_data && ovr_arm) begin
                overrun_flag <= 1'b0;
            end
            if (rd_stat) begin
                rx_arm <= rx_full_flag;
                ovr_arm <= overrun_flag;
            end else if (rd_data) begin
                rx_arm <= 1'b0;
                ovr_arm <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode fault. Detection off blocks the flag and, for a master, releases the select pin.
    logic fault_evt;
    assign fault_evt = unit_on && fault_detect_en &&
        (master_select ? !ss_n_in
                       : (run && !ss_prev && ss_n_in));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_arm <= 1'b0;
        end else begin
            if (fault_evt) begin
                mode_fault_flag <= 1'b1;
            end else if (wr_ctrl && mode_fault_flag_arm) begin
                mode_fault_flag <= 1'b0;
            end
            if (rd_stat) begin
                mode_fault_flag_arm <= mode_fault_flag;
            end else if (wr_ctrl) begin
                mode_fault_flag_arm <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel. Address and data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_addr <= '0;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SCSD_RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got <= 1'b1;
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got <= 1'b1;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                if (wr_addr == `SCSD_CTRL_OFS || wr_addr == `SCSD_STAT_OFS || wr_addr == `SCSD_DATA_OFS) begin
                    s_axi_bresp <= `SCSD_RESP_OK;
                end else begin
                    s_axi_bresp <= `SCSD_RESP_ERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel. Reads of the data word return the receive side.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SCSD_RESP_OK;
        end else if (rd_acc) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SCSD_RESP_OK;
            if (s_axi_araddr == `SCSD_CTRL_OFS) begin
                s_axi_rdata <= {24'h000000, rx_full_irq_en, 1'b0, master_select, clock_idle_level_sel,
                                clock_phase_sel, open_drain_sel, unit_on, tx_empty_irq_en};
            end else if (s_axi_araddr == `SCSD_STAT_OFS) begin
                s_axi_rdata <= {24'h000000, rx_full_flag, error_irq_en, overrun_flag, mode_fault_flag,
                                tx_empty_flag, fault_detect_en, baud_sel_hi, baud_sel_lo};
            end else if (s_axi_araddr == `SCSD_DATA_OFS) begin
                s_axi_rdata <= {24'h000000, rx_hold};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `SCSD_RESP_ERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers. Open-drain only ever pulls low, so a high is left to the wire.
    logic m_drv;
    logic s_drv;
    assign m_drv = unit_on && master_select;
    assign s_drv = sel;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            pullup_en <= 1'b1;
            ss_gpio_release <= 1'b1;
            irq_req <= 1'b0;
        end else begin
            sck_out <= open_drain_sel ? 1'b0 : sck_q;
            sck_oe <= m_drv && !(open_drain_sel && sck_q);
            mosi_out <= open_drain_sel ? 1'b0 : dout;
            mosi_oe <= m_drv && !(open_drain_sel && dout);
            miso_out <= open_drain_sel ? 1'b0 : dout;
            miso_oe <= s_drv && !(open_drain_sel && dout);
            pullup_en <= !open_drain_sel;
            ss_gpio_release <= !unit_on || (master_select && !fault_detect_en);
            irq_req <= (tx_empty_flag && tx_empty_irq_en) ||
                       (rx_full_flag && rx_full_irq_en) ||
                       (error_irq_en && (overrun_flag || mode_fault_flag));
        end
    end

endmodule : scsd_top
`default_nettype wire

/* File: dv/scsd_monitor.sv */
// Checker for the serial unit's bus handshakes and pad outputs.
// Assumes the port names of scsd_top; bound into every instance of it.
`timescale 1ns/10ps
`default_nettype none

module scsd_monitor (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins.
    input wire logic sck_out,
    input wire logic mosi_out,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire logic ss_n_in,
    input wire logic pullup_en,
    input wire logic ss_gpio_release,
    input wire logic irq_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////
    // The write is applied one cycle after it is taken, and the response is raised on that same edge.
    a_write_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_bresp_holds:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_rdata_holds:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    // One settled cycle is allowed, since the mode bit and the pins are both registered.
    a_od_no_high:
        assert property (!pullup_en && $past(!pullup_en) |-> !sck_out && !mosi_out && !miso_out)
        else $error("open-drain pin driven high");
    a_slave_float:
        assert property (ss_n_in [*3] |-> !miso_oe)
        else $error("output driven while deselected");
    a_irq_quiet:
        assert property ($rose(aresetn) |-> !irq_req)
        else $error("request raised out of reset");
    a_gpio_reset:
        assert property ($rose(aresetn) |-> ss_gpio_release && pullup_en)
        else $error("pad control wrong after reset");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_open_drain: cover property (!pullup_en);
endmodule : scsd_monitor

bind scsd_top scsd_monitor i_scsd_monitor (.*);

`default_nettype wire

/* File: dv/scsd_peer.sv */
// Behavioural peer slave at the far end of the serial link.
// Assumes idle-low clock, phase one at both ends, and pins seen on aclk.
`timescale 1ns/10ps
`default_nettype none

module scsd_peer
    import scsd_pkg::*;
(
    // Clock.
    input wire logic aclk,
    // Serial link.
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso,
    // Byte side.
    input wire scsd_byte_t tx_byte,
    output scsd_byte_t rx_byte
);
    logic sck_q = 1'h0;
    logic [2:0] cnt = 3'h0;
    scsd_byte_t sh = 8'h00;

    initial miso = 1'h0;
    initial rx_byte = 8'h00;

    ////////////////////////////////////////
    // Phase one lets select stay low between bytes, so bytes are framed by the bit count.
    always @(posedge aclk) begin
        sck_q <= sck;
        if (sel_n) begin
            // A released line must not look like held data, so it keeps changing.
            miso <= ~miso;
            cnt <= 3'h0;
        end else if (sck && !sck_q) begin
            miso <= (cnt == 3'h0) ? tx_byte[7] : sh[7];
            sh <= (cnt == 3'h0) ? {tx_byte[6:0], 1'h0} : {sh[6:0], 1'h0};
        end else if (!sck && sck_q) begin
            rx_byte <= {rx_byte[6:0], mosi};
            cnt <= cnt + 3'h1;
        end
    end
endmodule : scsd_peer

`default_nettype wire

/* File: dv/scsd_tb.sv */
// Self-checking bench for the serial unit as a master talking to a peer slave.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "scsd_regs.svh"

module scsd_tb;
    import scsd_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, pullup_en, ss_gpio_release, irq_req;
    logic sck_in, mosi_in, miso_in;
    logic ss_n_in = 1'h1, peer_sel_n = 1'h1;
    scsd_byte_t peer_tx = 8'h00, peer_rx;
    int err_count = 0, checks_done = 0, cyc = 0;

    always #5 aclk = ~aclk;
    // The clock line is pulled low so that enabling the unit makes no false edge.
    assign sck_in = sck_oe ? sck_out : 1'h0;
    assign mosi_in = mosi_oe ? mosi_out : 1'h1;

    scsd_top i_scsd_top (.*);
    scsd_peer i_scsd_peer (.aclk(aclk), .sck(sck_in), .mosi(mosi_in), .sel_n(peer_sel_n),
        .miso(miso_in), .tx_byte(peer_tx), .rx_byte(peer_rx));

    ////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= {24'h0, v};
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask : rchk

    task automatic waitbit(input int b);
        do rd(`SCSD_STAT_OFS); while (d[b] !== 1'h1);
    endtask : waitbit

    task automatic results;
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end

    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rchk(`SCSD_CTRL_OFS, 32'h28);
        rchk(`SCSD_STAT_OFS, 32'h08);
        rd(4'hC);
        chk(r, `SCSD_RESP_ERR);
        wr(`SCSD_STAT_OFS, 8'h01);
        wr(`SCSD_CTRL_OFS, 8'h2A);
        peer_sel_n <= 1'h0;
        peer_tx <= 8'hA5;
        wr(`SCSD_DATA_OFS, 8'h3C);
        waitbit(`SCSD_S_RXF);
        // The peer sees the last clock edge two cycles after the flag is set, through the registered pins.
        repeat (3) @(posedge aclk);
        chk(peer_rx, 8'h3C);
        rchk(`SCSD_DATA_OFS, 32'hA5);
        rchk(`SCSD_STAT_OFS, 32'h09);
        // Two bytes with no data read between them must overrun.
        peer_tx <= 8'h5A;
        wr(`SCSD_DATA_OFS, 8'hC3);
        waitbit(`SCSD_S_RXF);
        peer_tx <= 8'h0F;
        wr(`SCSD_DATA_OFS, 8'hF0);
        waitbit(`SCSD_S_OVR);
        repeat (3) @(posedge aclk);
        chk(peer_rx, 8'hF0);
        rchk(`SCSD_STAT_OFS, 32'hA9);
        rchk(`SCSD_DATA_OFS, 32'h5A);
        rchk(`SCSD_STAT_OFS, 32'h09);
        peer_sel_n <= 1'h1;
        wr(`SCSD_CTRL_OFS, 8'h2B);
        repeat (2) @(posedge aclk);
        chk(irq_req, 32'h1);
        wr(`SCSD_CTRL_OFS, 8'h2E);
        repeat (2) @(posedge aclk);
        chk(irq_req, 32'h0);
        chk(pullup_en, 32'h0);
        wr(`SCSD_CTRL_OFS, 8'h2A);
        ss_n_in <= 1'h0;
        repeat (4) @(posedge aclk);
        rchk(`SCSD_STAT_OFS, 32'h09);
        chk(ss_gpio_release, 32'h1);
        wr(`SCSD_STAT_OFS, 8'h05);
        repeat (2) @(posedge aclk);
        chk(ss_gpio_release, 32'h0);
        waitbit(`SCSD_S_MODE_FAULT_FLAG);
        ss_n_in <= 1'h1;
        wr(`SCSD_STAT_OFS, 8'h41);
        repeat (2) @(posedge aclk);
        chk(irq_req, 32'h1);
        rchk(`SCSD_STAT_OFS, 32'h59);
        wr(`SCSD_CTRL_OFS, 8'h2A);
        rchk(`SCSD_STAT_OFS, 32'h49);
        chk(irq_req, 32'h0);
        wr(`SCSD_CTRL_OFS, 8'h0A);
        repeat (4) @(posedge aclk);
        chk(miso_oe, 32'h0);
        wr(`SCSD_CTRL_OFS, 8'h08);
        repeat (2) @(posedge aclk);
        chk(ss_gpio_release, 32'h1);
        results();
    end
endmodule : scsd_tb

`default_nettype wire
